// ==== core/ssr_spi_slave.sv ====
// How it works
// - Status byte shifts out on first bytes
// - Bit 6 shows oscillator running
// - Bit 5 sticky underflow, cleared by flush
// - Bit 4 shows cipher engine busy
// - Bit 3 shows transmission active
// - Bit 2 shows synthesizer lock
// - Bit 1 valid after 128 us receive
// - No-operation strobe gives no pulse, only latches its code
// - Oscillator off: only oscillator-on strobe accepted
// - Other strobes dropped unless oscillator stable
// - Strobe is one byte, codes 0x00-0x0E
// - Strobe runs on last falling edge
// - RAM address once, then auto-increment
// - RAM bit set, bank plus offset address
// - Banks: transmit, receive, security areas
// - Second byte: bank, read-only bit
// - RAM write returns old contents
// - RAM read data follows second byte
// - RAM contents have no reset
// - All bits most significant first
// - Register access is 24 bits
// - Output released while select high
`include "ssr_consts.svh"

module ssr_spi_slave
  import ssr_pkg::*;
#(
  parameter int unsigned RSSI_CYCLES = `SSR_RSSI_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic selectLow,
  input wire logic sclkPin,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic oscStableFlag,
  input wire logic txUnderflow,
  input wire logic cipherBusyFlag,
  input wire logic txActive,
  input wire logic pllLocked,
  input wire logic rxEnabled,
  output ssr_strobe_t strobe,
  output ssr_reg_req_t regReq,
  input wire logic [15:0] regRdData,
  output ssr_status_t status
);

  // Strobe code range check
  function automatic logic isStrobe(input logic [7:0] b);
    isStrobe = (b[7:6] == 2'h0) && (b[5:0] <= `SSR_STROBE_MAX);
  endfunction : isStrobe

  // RAM bounds check
  function automatic logic inRam(input logic [8:0] a);
    inRam = (a <= `SSR_RAM_LAST);
  endfunction : inRam

  logic [1:0] sclkSync;
  logic [1:0] csnSync;
  logic [1:0] siSync;
  logic sclkD;
  logic csnD;
  logic sclkS;
  logic csnS;
  logic siS;
  logic sclkRise;
  logic sclkFall;
  logic csnFall;
  logic [2:0] bitCntQ;
  logic byteDoneQ;
  logic [7:0] rxShiftQ;
  logic [7:0] soShiftQ;
  logic soOeQ;
  ssr_state_t stateQ;
  ssr_state_t stateD;
  logic [7:0] txLoadD;
  logic rwQ;
  logic ramRoQ;
  logic [8:0] ramAddrQ;
  logic [8:0] ramNextAddr;
  logic [7:0] ramRdData;
  logic [6:0] txPtrQ;
  logic [7:0] regHiQ;
  logic underflowQ;
  logic [15:0] rssiCntQ;
  logic rssiValidQ;
  logic byteEnd;
  logic strobeAccept;
  logic flushExec;
  ssr_strobe_t strobeQ;
  ssr_reg_req_t regReqQ;
  logic [7:0] ram [`SSR_RAM_BYTES];

  // Pin synchronisers; edges are found on the second stage only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkSync <= 2'h0;
      csnSync <= 2'h3;
      siSync <= 2'h0;
      sclkD <= 1'b0;
      csnD <= 1'b1;
    end else if (ce) begin
      sclkSync <= {sclkSync[0], sclkPin};
      csnSync <= {csnSync[0], selectLow};
      siSync <= {siSync[0], serialIn};
      sclkD <= sclkSync[1];
      csnD <= csnSync[1];
    end
  end

  assign sclkS = sclkSync[1];
  assign csnS = csnSync[1];
  assign siS = siSync[1];
  assign sclkRise = ce && !csnS && sclkS && !sclkD;
  assign sclkFall = ce && !csnS && !sclkS && sclkD;
  assign csnFall = ce && !csnS && csnD;
  assign byteEnd = sclkFall && byteDoneQ;

  // Status byte, reserved bits read zero
  // oscillator flag
  always_comb begin
    status = '0;
    status.oscStable = oscStableFlag;
    status.txUnderflow = underflowQ;
    status.cipherBusy = cipherBusyFlag;
    status.txActive = txActive;
    status.pllLocked = pllLocked;
    status.rssiValid = rssiValidQ;
  end

  // sample on rising edge, framing cleared by select
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCntQ <= 3'h0;
      byteDoneQ <= 1'b0;
      rxShiftQ <= 8'h00;
    end else if (ce) begin
      if (csnS) begin
        bitCntQ <= 3'h0;
        byteDoneQ <= 1'b0;
      end else if (sclkRise) begin
        rxShiftQ <= {rxShiftQ[6:0], siS};
        bitCntQ <= bitCntQ + 3'h1;
        byteDoneQ <= (bitCntQ == 3'h7);
      end else if (sclkFall) begin
        byteDoneQ <= 1'b0;
      end
    end
  end

  // Next RAM address: bank from second byte, else step by one
  // bank select above offset
  assign ramNextAddr = (stateQ == SSR_RAM_ADR2) ? {rxShiftQ[7:6], ramAddrQ[6:0]} : ramAddrQ + 9'h001;
  // addresses past the security bank read zero
  assign ramRdData = inRam(ramNextAddr) ? ram[ramNextAddr] : 8'h00;

  // Byte decode and next byte to shift out
  always_comb begin
    stateD = stateQ;
    txLoadD = 8'h00;
    case (stateQ)
      SSR_CMD: begin
        if (rxShiftQ[7]) begin
          stateD = SSR_RAM_ADR2;
        end else if (isStrobe(rxShiftQ)) begin
          txLoadD = status;
        end else if (!rxShiftQ[6] && rxShiftQ[5:0] == `SSR_TRANSMIT_QUEUE_REG) begin
          stateD = SSR_TXQ;
          txLoadD = status;
        end else if (rxShiftQ[5:0] == `SSR_TRANSMIT_QUEUE_REG || rxShiftQ[5:0] == `SSR_RECEIVE_QUEUE_REG) begin
          stateD = SSR_IGNORE;
        end else begin
          stateD = SSR_REG_HI;
          txLoadD = rxShiftQ[6] ? regRdData[15:8] : 8'h00;
        end
      end
      SSR_REG_HI: begin
        stateD = SSR_REG_LO;
        txLoadD = rwQ ? regRdData[7:0] : 8'h00;
      end
      SSR_REG_LO: begin
        stateD = SSR_CMD;
        txLoadD = status;
      end
      SSR_RAM_ADR2: begin
        // first data byte right after the address
        stateD = SSR_RAM_DATA;
        txLoadD = ramRdData;
      end
      SSR_RAM_DATA: begin
        // old contents go out while new ones come in
        txLoadD = ramRdData;
      end
      SSR_TXQ: begin
        txLoadD = status;
      end
      SSR_IGNORE: begin
        txLoadD = 8'h00;
      end
      default: begin
        stateD = SSR_CMD;
      end
    endcase
  end

  // Framing state; RAM and queue accesses only end with select
  // register access takes three bytes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stateQ <= SSR_CMD;
      rwQ <= 1'b0;
      ramRoQ <= 1'b0;
      ramAddrQ <= 9'h000;
    end else if (ce) begin
      if (csnS) begin
        stateQ <= SSR_CMD;
      end else if (byteEnd) begin
        stateQ <= stateD;
        if (stateQ == SSR_CMD) begin
          rwQ <= rxShiftQ[6];
          ramAddrQ <= {2'h0, rxShiftQ[6:0]};
        end
        if (stateQ == SSR_RAM_ADR2) begin
          ramRoQ <= rxShiftQ[5];
        end
        if (stateQ == SSR_RAM_ADR2 || stateQ == SSR_RAM_DATA) begin
          ramAddrQ <= ramNextAddr;
        end
      end
    end
  end

  // RAM array, no reset so contents survive power-down
  // write unless read-only bit was set
  always_ff @(posedge clk) begin
    if (ce && byteEnd) begin
      if (stateQ == SSR_RAM_DATA && !ramRoQ && inRam(ramAddrQ)) begin
        ram[ramAddrQ] <= rxShiftQ;
      end else if (stateQ == SSR_TXQ) begin
        ram[{2'h0, txPtrQ}] <= rxShiftQ;
      end
    end
  end

  // Transmit queue fill pointer, flushed by strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txPtrQ <= 7'h00;
    end else if (ce) begin
      if (flushExec) begin
        txPtrQ <= 7'h00;
      end else if (byteEnd && stateQ == SSR_TXQ) begin
        txPtrQ <= txPtrQ + 7'h01;
      end
    end
  end

  // Output shifter: status ready before the first rising edge
  // change on falling edge, MSB first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      soShiftQ <= 8'h00;
      soOeQ <= 1'b0;
    end else if (ce) begin
      soOeQ <= !csnS;
      if (csnFall) begin
        soShiftQ <= status;
      end else if (byteEnd) begin
        soShiftQ <= txLoadD;
      end else if (sclkFall) begin
        soShiftQ <= {soShiftQ[6:0], 1'b0};
      end
    end
  end

  assign serialOut = soShiftQ[7];
  assign serialOutEn = soOeQ;

  // Strobe acceptance; a dead oscillator only takes oscillator-on
  // gate on oscillator flag
  assign strobeAccept = byteEnd && stateQ == SSR_CMD && isStrobe(rxShiftQ)
                        && (oscStableFlag || rxShiftQ[5:0] == `SSR_OSCILLATOR_ON_STROBE);
  assign flushExec = strobeAccept && rxShiftQ[5:0] == `SSR_TRANSMIT_FLUSH_STROBE;

  // pulse on last falling edge, none for no-operation
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobeQ <= '0;
    end else if (ce) begin
      strobeQ.valid <= strobeAccept && rxShiftQ[5:0] != `SSR_NO_OPERATION_STROBE;
      if (strobeAccept) begin
        strobeQ.code <= rxShiftQ[5:0];
      end
    end
  end
  assign strobe = strobeQ;

  // Register port: address known before read data is needed
  // write word loaded after last data bit
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regReqQ <= '0;
      regHiQ <= 8'h00;
    end else if (ce) begin
      regReqQ.write <= 1'b0;
      if (sclkRise && bitCntQ == 3'h7 && stateQ == SSR_CMD) begin
        regReqQ.addr <= {rxShiftQ[4:0], siS};
      end
      if (byteEnd && stateQ == SSR_REG_HI) begin
        regHiQ <= rxShiftQ;
      end
      if (byteEnd && stateQ == SSR_REG_LO && !rwQ) begin
        regReqQ.write <= 1'b1;
        regReqQ.data <= {regHiQ, rxShiftQ};
      end
    end
  end
  assign regReq = regReqQ;

  // underflow sticky; a new event beats the flush
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      underflowQ <= 1'b0;
    end else if (ce) begin
      if (txUnderflow) begin
        underflowQ <= 1'b1;
      end else if (flushExec) begin
        underflowQ <= 1'b0;
      end
    end
  end

  // signal strength valid after settle time in receive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rssiCntQ <= 16'h0000;
      rssiValidQ <= 1'b0;
    end else if (ce) begin
      if (!rxEnabled) begin
        rssiCntQ <= 16'h0000;
        rssiValidQ <= 1'b0;
      end else begin
        if (rssiCntQ != RSSI_CYCLES[15:0]) begin
          rssiCntQ <= rssiCntQ + 16'h0001;
        end
        rssiValidQ <= (rssiCntQ == RSSI_CYCLES[15:0]);
      end
    end
  end

  // Checks
  sequence seqSelIdle;
    ce && csnS;
  endsequence

  sequence seqFrameClear;
    stateQ == SSR_CMD && bitCntQ == 3'h0;
  endsequence

  chk_output_release: assert property (@(posedge clk) disable iff (!reset_n)
    seqSelIdle |=> !serialOutEn) else $error("serial output driven while deselected");

  chk_frame_restart: assert property (@(posedge clk) disable iff (!reset_n)
    seqSelIdle |=> seqFrameClear) else $error("framing not cleared by select");

  chk_status_first: assert property (@(posedge clk) disable iff (!reset_n)
    csnFall |=> soShiftQ == $past(status)) else $error("status byte not loaded at select");

  chk_strobe_gate: assert property (@(posedge clk) disable iff (!reset_n)
    strobe.valid |-> $past(oscStableFlag) || strobe.code == `SSR_OSCILLATOR_ON_STROBE)
    else $error("strobe accepted with oscillator off");

  chk_strobe_edge: assert property (@(posedge clk) disable iff (!reset_n)
    strobe.valid |-> $past(sclkFall) && $past(stateQ) == SSR_CMD) else $error("strobe off its falling edge");

  chk_underflow_set: assert property (@(posedge clk) disable iff (!reset_n)
    ce && txUnderflow |=> status.txUnderflow) else $error("underflow event lost");

  chk_underflow_hold: assert property (@(posedge clk) disable iff (!reset_n)
    ce && underflowQ && !flushExec |=> underflowQ) else $error("underflow cleared without flush");

  chk_rssi_drop: assert property (@(posedge clk) disable iff (!reset_n)
    ce && !rxEnabled |=> !status.rssiValid) else $error("signal valid without receive");

  chk_ram_step: assert property (@(posedge clk) disable iff (!reset_n)
    byteEnd && stateQ == SSR_RAM_DATA |=> ramAddrQ == $past(ramAddrQ) + 9'h001) else $error("RAM address not stepped");

  chk_reg_write: assert property (@(posedge clk) disable iff (!reset_n)
    regReq.write |-> $past(stateQ) == SSR_REG_LO && !$past(rwQ)) else $error("register write out of frame");

  chk_noop_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    strobe.valid |-> strobe.code != `SSR_NO_OPERATION_STROBE) else $error("no-operation strobe had effect");

endmodule : ssr_spi_slave

// ==== core/ssr_consts.svh ====
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH

// Status byte bit positions
`define SSR_BIT_OSC_STABLE 6
`define SSR_BIT_TX_UNDERFLOW 5
`define SSR_BIT_CIPHER_BUSY 4
`define SSR_BIT_TX_ACTIVE 3
`define SSR_BIT_PLL_LOCK 2
`define SSR_BIT_SIGNAL_STRENGTH_VALID_FLAG 1

// Command strobe codes (plain defaults, only the range is fixed)
`define SSR_STROBE_MAX 6'h0E
`define SSR_NO_OPERATION_STROBE 6'h00
`define SSR_OSCILLATOR_ON_STROBE 6'h01
`define SSR_TRANSMIT_FLUSH_STROBE 6'h02

// Queue register addresses
`define SSR_TRANSMIT_QUEUE_REG 6'h3E
`define SSR_RECEIVE_QUEUE_REG 6'h3F

// RAM layout, linear 9-bit addresses
`define SSR_RAM_BYTES 368
`define SSR_RAM_LAST 9'h16F
`define SSR_TRANSMIT_QUEUE_BASE 9'h000
`define SSR_RECEIVE_QUEUE_BASE 9'h080
`define SSR_SECURITY_BASE 9'h100
`define SSR_CIPHER_KEY_ZERO 9'h100
`define SSR_RECEIVE_NONCE_COUNTER 9'h110
`define SSR_STANDALONE_CIPHER_BUFFER 9'h120
`define SSR_CIPHER_KEY_ONE 9'h130
`define SSR_TRANSMIT_NONCE_COUNTER 9'h140
`define SSR_MAC_CHAIN_SCRATCH 9'h150
`define SSR_LONG_NODE_ADDRESS 9'h160
`define SSR_NETWORK_IDENTIFIER 9'h168
`define SSR_SHORT_NODE_ADDRESS 9'h16A

// Timing
`define SSR_CLK_PERIOD_NS 5
`define SSR_RSSI_TIME_NS 128000
`define SSR_RSSI_CYCLES ((`SSR_RSSI_TIME_NS + `SSR_CLK_PERIOD_NS - 1) / `SSR_CLK_PERIOD_NS)

`endif

// ==== core/ssr_pkg.sv ====
package ssr_pkg;

  // Serial framing states
  typedef enum logic [2:0] {
    SSR_CMD,
    SSR_REG_HI,
    SSR_REG_LO,
    SSR_RAM_ADR2,
    SSR_RAM_DATA,
    SSR_TXQ,
    SSR_IGNORE
  } ssr_state_t;

  // Status byte as shifted out, bit 7 first
  typedef struct packed {
    logic rsvd7;
    logic oscStable;
    logic txUnderflow;
    logic cipherBusy;
    logic txActive;
    logic pllLocked;
    logic rssiValid;
    logic rsvd0;
  } ssr_status_t;

  typedef struct packed {
    logic valid;
    logic [5:0] code;
  } ssr_strobe_t;

  typedef struct packed {
    logic write;
    logic [5:0] addr;
    logic [15:0] data;
  } ssr_reg_req_t;

endpackage : ssr_pkg

// ==== tb/ssr_host_model.sv ====
module ssr_host_model (
  input wire logic clk,
  output logic selectLow,
  output logic sclkPin,
  output logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn,
  output logic rxDone,
  output logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic alt = 1'b0;

  // Undriven output shows a moving pattern, never a held level
  always @(posedge clk) begin
    alt <= ~alt;
  end

  // Idle: deselected, serial clock parked low
  initial begin
    selectLow = 1'b1;
    sclkPin = 1'b0;
    serialIn = 1'b0;
    rxDone = 1'b0;
    rxByte = 8'h00;
  end

  // select opens the frame, setup before first rise
  task open_frame();
    repeat (2) @(negedge clk);
    selectLow = 1'b0;
    repeat (8) @(negedge clk);
  endtask : open_frame

  task byte_xfer(input logic [7:0] tx);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      serialIn = tx[i];
      repeat (8) @(negedge clk);
      sclkPin = 1'b1;
      repeat (8) @(negedge clk);
      rx[i] = (serialOutEn === 1'b1) ? serialOut : alt; // Sampled just before the fall
      sclkPin = 1'b0;
    end
    rxByte = rx;
    rxDone = 1'b1;
    @(negedge clk);
    rxDone = 1'b0;
  endtask : byte_xfer

  // RAM and queue accesses end only by raising select
  task close_frame();
    repeat (8) @(negedge clk);
    selectLow = 1'b1;
    repeat (8) @(negedge clk);
    serialIn = ~serialIn;
  endtask : close_frame
endmodule : ssr_host_model

// ==== tb/ssr_spi_slave_test.sv ====
module ssr_spi_slave_test import ssr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned RSSI_N = 20;
  logic clk, reset_n, ce, oscStableFlag, txUnderflow, cipherBusyFlag, txActive, pllLocked, rxEnabled;
  logic selectLow, sclkPin, serialIn, serialOut, serialOutEn, rxDone;
  logic [7:0] rxByte;
  logic [15:0] regRdData;
  ssr_strobe_t strobe;
  ssr_reg_req_t regReq;
  ssr_status_t status;
  logic undExp, rssiExp;
  logic [31:0] seed = 32'h6389;
  logic [7:0] sh [0:511];
  logic [15:0] expByte [$];
  logic [31:0] expEvt [$];
  int fails = 0;
  int checked = 0;

  ssr_spi_slave #(.RSSI_CYCLES(RSSI_N)) u_ssr_spi_slave (.clk(clk), .reset_n(reset_n), .ce(ce),
    .selectLow(selectLow), .sclkPin(sclkPin), .serialIn(serialIn), .serialOut(serialOut),
    .serialOutEn(serialOutEn), .oscStableFlag(oscStableFlag), .txUnderflow(txUnderflow),
    .cipherBusyFlag(cipherBusyFlag), .txActive(txActive), .pllLocked(pllLocked), .rxEnabled(rxEnabled),
    .strobe(strobe), .regReq(regReq), .regRdData(regRdData), .status(status));
  ssr_host_model u_ssr_host_model (.clk(clk), .selectLow(selectLow), .sclkPin(sclkPin),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn), .rxDone(rxDone), .rxByte(rxByte));

  // Register file stand-in, follows the latched address
  assign regRdData = {regReq.addr, 2'b11, ~regReq.addr, 2'b00};

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [7:0] stat();
    return {1'b0, oscStableFlag, undExp, cipherBusyFlag, txActive, pllLocked, rssiExp, 1'b0};
  endfunction : stat

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task send(input logic [7:0] tx, input logic [7:0] mask, input logic [7:0] val);
    expByte.push_back({mask, val & mask});
    u_ssr_host_model.byte_xfer(tx);
  endtask : send

  task sst(input logic [7:0] tx);
    send(tx, 8'h7E, stat());
  endtask : sst

  // fresh random status levels per frame
  task open_f();
    logic [31:0] r;
    r = xs();
    @(negedge clk);
    cipherBusyFlag = r[0];
    txActive = r[1];
    pllLocked = r[2];
    u_ssr_host_model.open_frame();
  endtask : open_f

  task close_f();
    u_ssr_host_model.close_frame();
    check({31'h0, serialOutEn}, 32'h0);
  endtask : close_f

  // two address bytes, then one byte per step
  task ram_frame(input logic [8:0] a, input logic ro, input int n);
    logic [8:0] p;
    logic [7:0] d, mk, ev;
    open_f();
    sst({1'b1, a[6:0]});
    send({a[8:7], ro, 5'b10101}, 8'hFF, 8'h00);
    p = a;
    for (int i = 0; i < n; i++) begin
      d = 8'(xs());
      mk = (p > 9'h16F || ^sh[p] !== 1'bx) ? 8'hFF : 8'h00;
      ev = (p > 9'h16F) ? 8'h00 : sh[p];
      send(d, mk, ev);
      if (!ro && p <= 9'h16F) sh[p] = d;
      p++;
    end
    close_f();
  endtask : ram_frame

  task print_verdict();
    fails += expByte.size() + expEvt.size();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Results meet their notes in order; an unnoted pulse fails
  always @(posedge clk) begin
    logic [15:0] e;
    if (rxDone === 1'b1) begin
      e = (expByte.size() > 0) ? expByte.pop_front() : 16'h00FF;
      check({24'h0, rxByte & e[15:8]}, {24'h0, e[7:0]});
    end
  end

  // Registered pulses looked at mid-cycle, away from their launching edge
  always @(negedge clk) begin
    logic [31:0] v;
    if (strobe.valid === 1'b1) begin
      v = (expEvt.size() > 0) ? expEvt.pop_front() : 32'hFFFFFFFF;
      check({8'h01, 18'h0, strobe.code}, v);
    end
    if (regReq.write === 1'b1) begin
      v = (expEvt.size() > 0) ? expEvt.pop_front() : 32'hFFFFFFFF;
      check({8'h02, 2'b00, regReq.addr, regReq.data}, v);
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    int c;
    logic [31:0] d;
    {ce, reset_n, oscStableFlag, txUnderflow, cipherBusyFlag, txActive, pllLocked, rxEnabled} = 8'h80;
    {undExp, rssiExp} = 2'b00;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    check({24'h0, status}, 32'h0);
    // only oscillator start while off or unstable
    open_f();
    sst(8'h02);
    expEvt.push_back(32'h01000001);
    sst(8'h01);
    sst(8'h03);
    close_f();
    // oscillator runs before any RAM traffic
    @(negedge clk);
    oscStableFlag = 1'b1;
    txUnderflow = 1'b1;
    @(negedge clk);
    txUnderflow = 1'b0;
    undExp = 1'b1;
    // every code back to back, flush last
    open_f();
    sst(8'h00);
    for (int i = 3; i <= 16; i++) begin
      c = (i > 14) ? i - 14 : i;
      expEvt.push_back({8'h01, 18'h0, c[5:0]});
      sst({2'b00, c[5:0]});
    end
    close_f();
    undExp = 1'b0;
    // register write then transmit queue in one period
    d = xs();
    open_f();
    sst(8'h10);
    expEvt.push_back({8'h02, 2'b00, 6'h10, d[15:0]});
    send(d[15:8], 8'hFF, 8'h00);
    send(d[7:0], 8'hFF, 8'h00);
    sst(8'h3E);
    sst(d[23:16]);
    sst(d[31:24]);
    close_f();
    sh[0] = d[23:16];
    sh[1] = d[31:24];
    ram_frame(9'h000, 1'b1, 2);
    open_f();
    sst(8'h55);
    send(8'h00, 8'hFF, {6'h15, 2'b11});
    send(8'h00, 8'hFF, {~6'h15, 2'b00});
    close_f();
    // read cut short, next period starts afresh
    open_f();
    sst(8'h6A);
    send(8'h00, 8'hFF, {6'h2A, 2'b11});
    close_f();
    open_f();
    sst(8'h00);
    close_f();
    for (int j = 0; j < 4; j++) ram_frame(9'h0FE, j[1], 4);
    ram_frame(9'h16A, 1'b0, 7);
    ram_frame(9'h16A, 1'b1, 7);
    // strength valid once receive has settled
    @(negedge clk);
    rxEnabled = 1'b1;
    repeat (RSSI_N + 10) @(negedge clk);
    rssiExp = 1'b1;
    open_f();
    sst(8'h00);
    close_f();
    rxEnabled = 1'b0;
    repeat (2) @(negedge clk);
    rssiExp = 1'b0;
    open_f();
    sst(8'h00);
    close_f();
    repeat (20) @(negedge clk);
    print_verdict();
  end
endmodule : ssr_spi_slave_test
